// File: rtl/rcc_consts.svh
// rcc_consts.svh: register offsets, flag positions, cause mask, opcode, trap levels and responses of the reset cause block
// assumes: included by the package and the design file by bare name
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
`define RCC_OFF_CAUSE      8'h00
`define RCC_OFF_WREG       8'h04
`define RCC_OFF_CLK        8'h08
`define RCC_BIT_POR        0
`define RCC_BIT_BOR        1
`define RCC_BIT_IDLE       2
`define RCC_BIT_SLEEP      3
`define RCC_BIT_WDOG       4
`define RCC_BIT_SWR        6
`define RCC_BIT_EXT        7
`define RCC_BIT_ILL        14
`define RCC_BIT_TRAP       15
`define RCC_CAUSE_MASK     16'hC0DF
`define RCC_ILLEGAL_OPHI   8'h3F
`define RCC_HARD_LVL_LO    4'hD
`define RCC_HARD_LVL_HI    4'hF
`define RCC_RSP_OKAY       2'h0
`define RCC_RSP_SLVERR     2'h2
`endif

// File: rtl/rcc_pkg.sv
// rcc_pkg.sv: types shared by the reset cause block
// assumes: rcc_consts.svh sits beside it
`include "rcc_consts.svh"
package rcc_pkg;
    typedef enum logic [2:0] {
        RCC_RUN  = 3'b001,
        RCC_HOLD = 3'b010,
        RCC_FETCH = 3'b100
    } rcc_state_t;
endpackage

// File: rtl/rcc_reset_cause.sv
// rcc_reset_cause.sv: warm reset sequencer, cause register and working register init tracking
// assumes: one 200 MHz clock; rst_i is the cold (power-on / brown-out) reset; pin input is asynchronous
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`include "rcc_consts.svh"
module rcc_reset_cause
    import rcc_pkg::*;
#(
    parameter int NUM_WREG = 16,
    parameter int CLK_W    = 3
) (
    // clock and cold reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    input  wire logic                brownout_i,
    // core events, one-cycle pulses
    input  wire logic                instr_valid_i,
    input  wire logic [23:0]         instr_word_i,
    input  wire logic                sw_reset_instr_i,
    input  wire logic                power_save_instr_i,
    input  wire logic                power_save_idle_i,
    input  wire logic                wdog_clear_instr_i,
    input  wire logic                wake_i,
    input  wire logic                wreg_wr_i,
    input  wire logic [3:0]          wreg_wr_idx_i,
    input  wire logic                wreg_ptr_use_i,
    input  wire logic [3:0]          wreg_ptr_idx_i,
    input  wire logic                security_reset_i,
    // watchdog and trap logic
    input  wire logic                dog_timer_timeout_i,
    input  wire logic                trap_active_i,
    input  wire logic [3:0]          trap_active_lvl_i,
    input  wire logic                trap_new_i,
    input  wire logic [3:0]          trap_new_lvl_i,
    // clock selection
    input  wire logic [CLK_W-1:0]    clk_sel_new_i,
    input  wire logic                clk_sel_wr_i,
    // external pin
    input  wire logic                ext_reset_pin_n_i,
    // outputs to the core
    output logic                     system_reset_n_o,
    output logic                     vector_fetch_o,
    output logic                     wake_o,
    output logic [NUM_WREG-1:0]      wreg_init_o,
    output logic [CLK_W-1:0]         clk_sel_o,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);
    // index ports are four bits and the read mux pads to one word
    if (NUM_WREG != 16 || CLK_W < 1 || CLK_W > 8) begin : g_bad_param
        $error("rcc: unsupported parameters");
    end

    function automatic logic [15:0] bit16(input int pos);
        bit16 = 16'h0001 << pos;
    endfunction

    // pin and brown-out synchronisers
    logic [1:0] pin_sync;
    logic [1:0] bor_sync;
    logic       bor_seen;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_sync <= 2'h3;
            bor_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], ext_reset_pin_n_i};
            bor_sync <= {bor_sync[0], brownout_i};
        end
    end
    wire pin_low = ~pin_sync[1];
    wire bor_now = bor_sync[1];

    // event decode
    logic       sleeping;
    wire        ill_opcode = instr_valid_i && instr_word_i[23:16] == `RCC_ILLEGAL_OPHI;
    wire        wreg_uninit = wreg_ptr_use_i && !wreg_init_o[wreg_ptr_idx_i];
    wire        ill_event  = ill_opcode || wreg_uninit || security_reset_i;
    wire        trap_hard  = trap_new_i && trap_new_lvl_i >= `RCC_HARD_LVL_LO;
    wire        trap_confl = trap_hard && trap_active_i && trap_active_lvl_i > trap_new_lvl_i;
    wire        wdog_reset = dog_timer_timeout_i && !sleeping;
    wire        warm_event = sw_reset_instr_i || wdog_reset || trap_confl || ill_event || pin_low;

    // sequencer: hold while a source stands, then one fetch cycle
    rcc_state_t state;
    wire        hold_now = pin_low || bor_now;
    wire rcc_state_t next_state = (warm_event || hold_now) ? RCC_HOLD :
                                  (state == RCC_HOLD) ? RCC_FETCH : RCC_RUN;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state            <= RCC_HOLD;
            system_reset_n_o <= 1'b0;
            vector_fetch_o   <= 1'b0;
        end else begin
            state            <= next_state;
            system_reset_n_o <= next_state != RCC_HOLD;
            vector_fetch_o   <= next_state == RCC_FETCH;
        end
    end

    // sleep/idle tracking and wake
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sleeping <= 1'b0;
            wake_o   <= 1'b0;
        end else begin
            sleeping <= (sleeping || power_save_instr_i) && !wake_i && !dog_timer_timeout_i
                        && !warm_event;
            wake_o   <= dog_timer_timeout_i && sleeping;
        end
    end

    // working register init tracking, stack pointer always initialised
    wire [NUM_WREG-1:0] wr_onehot = wreg_wr_i ? (NUM_WREG'(1) << wreg_wr_idx_i) : '0;
    wire [NUM_WREG-1:0] sp_bit    = NUM_WREG'(1) << (NUM_WREG - 1);
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            // stack pointer counts as written from cold reset on, as after a warm one
            wreg_init_o <= {1'b1, {(NUM_WREG-1){1'b0}}};
            bor_seen    <= 1'b0;
        end else begin
            bor_seen    <= bor_now;
            if (next_state == RCC_HOLD) begin
                wreg_init_o <= sp_bit;
            end else begin
                wreg_init_o <= wreg_init_o | wr_onehot | sp_bit;
            end
        end
    end

    // clock selection survives warm resets; only cold reset defaults it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clk_sel_o <= '0;
        end else if (clk_sel_wr_i && state == RCC_RUN) begin
            clk_sel_o <= clk_sel_new_i;
        end
    end

    // axi4-lite slave: accept address and data in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         wr_go     = aw_held && w_held && !s_axi_bvalid;
    wire         wr_cause  = wr_go && aw_addr == `RCC_OFF_CAUSE;
    wire         wr_mapped = aw_addr == `RCC_OFF_CAUSE || aw_addr == `RCC_OFF_WREG || aw_addr == `RCC_OFF_CLK;
    wire         aw_take   = s_axi_awvalid && s_axi_awready;
    wire         w_take    = s_axi_wvalid && s_axi_wready;
    wire         next_aw_held = aw_take || (aw_held && !wr_go);
    wire         next_w_held  = w_take || (w_held && !wr_go);
    wire         next_bvalid  = wr_go || (s_axi_bvalid && !s_axi_bready);
    // ready flags are registered from the next state, so no bus output is combinational
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RCC_RSP_OKAY;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
            s_axi_bvalid  <= next_bvalid;
            if (aw_take) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                s_axi_bresp <= wr_mapped ? `RCC_RSP_OKAY : `RCC_RSP_SLVERR;
            end
        end
    end

    // cause register: events win over a software write in the same cycle
    logic [15:0] reset_cause_flags;
    wire  [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}} & `RCC_CAUSE_MASK;
    wire  [15:0] sw_value  = (reset_cause_flags & ~lane_mask) | (w_data[15:0] & lane_mask);
    wire  [15:0] base      = wr_cause ? sw_value : reset_cause_flags;
    wire  [15:0] set_bits  = (sw_reset_instr_i ? bit16(`RCC_BIT_SWR) : 16'h0000)
                           | (dog_timer_timeout_i && !sleeping ? bit16(`RCC_BIT_WDOG) : 16'h0000)
                           | (trap_confl ? bit16(`RCC_BIT_TRAP) : 16'h0000)
                           | (ill_event ? bit16(`RCC_BIT_ILL) : 16'h0000)
                           | (pin_low ? bit16(`RCC_BIT_EXT) : 16'h0000)
                           | (bor_now && !bor_seen ? bit16(`RCC_BIT_BOR) : 16'h0000)
                           | (power_save_instr_i ? (power_save_idle_i ? bit16(`RCC_BIT_IDLE)
                                                                       : bit16(`RCC_BIT_SLEEP)) : 16'h0000);
    wire         wd_clear  = power_save_instr_i || wdog_clear_instr_i;
    // brown-out keeps its own flag while the level stands, or it would erase itself
    wire  [15:0] bor_clr   = bor_now ? (`RCC_CAUSE_MASK & ~bit16(`RCC_BIT_EXT) & ~bit16(`RCC_BIT_POR)
                                        & ~bit16(`RCC_BIT_BOR)) : 16'h0000;
    wire  [15:0] clr_bits  = (wd_clear ? bit16(`RCC_BIT_WDOG) : 16'h0000) | bor_clr;
    wire  [15:0] next_flags = (base & ~clr_bits) | set_bits;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_cause_flags <= bit16(`RCC_BIT_POR) | bit16(`RCC_BIT_BOR);
        end else begin
            reset_cause_flags <= next_flags;
        end
    end

    // read channel
    wire [31:0] rd_mux = s_axi_araddr == `RCC_OFF_CAUSE ? {16'h0000, reset_cause_flags} :
                         s_axi_araddr == `RCC_OFF_WREG  ? {{(32-NUM_WREG){1'b0}}, wreg_init_o} :
                         s_axi_araddr == `RCC_OFF_CLK   ? {{(32-CLK_W){1'b0}}, clk_sel_o} : 32'h0000_0000;
    wire        rd_ok  = s_axi_araddr == `RCC_OFF_CAUSE || s_axi_araddr == `RCC_OFF_WREG
                         || s_axi_araddr == `RCC_OFF_CLK;
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RCC_RSP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid  <= 1'b1;
            s_axi_arready <= 1'b0;
            s_axi_rdata   <= rd_mux;
            s_axi_rresp   <= rd_ok ? `RCC_RSP_OKAY : `RCC_RSP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // checks
    swr_pulse_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sw_reset_instr_i && !hold_now |=> !system_reset_n_o ##1 system_reset_n_o && vector_fetch_o)
        else $error("software reset not released after one cycle");
    swr_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sw_reset_instr_i |=> reset_cause_flags[`RCC_BIT_SWR])
        else $error("software reset flag not set");
    swr_clock_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !system_reset_n_o |=> $stable(clk_sel_o))
        else $error("clock source changed during reset");
    wdog_reset_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dog_timer_timeout_i && !sleeping |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_WDOG])
        else $error("watchdog time-out did not reset");
    wdog_sleep_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dog_timer_timeout_i && sleeping && !warm_event && !hold_now |=> system_reset_n_o && wake_o)
        else $error("watchdog in sleep must only wake");
    wdog_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wd_clear && !dog_timer_timeout_i |=> !reset_cause_flags[`RCC_BIT_WDOG])
        else $error("watchdog flag not cleared");
    trap_conf_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        trap_confl |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_TRAP])
        else $error("trap conflict not handled");
    ill_opc_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        instr_valid_i && instr_word_i[23:16] == 8'h3F |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_ILL])
        else $error("illegal opcode not caught");
    wreg_clear_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !system_reset_n_o |-> wreg_init_o == sp_bit)
        else $error("working registers not uninitialised in reset");
    ext_pin_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ext_reset_pin_n_i ##1 !ext_reset_pin_n_i ##1 !ext_reset_pin_n_i |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_EXT])
        else $error("pin reset not taken");
    bor_flag_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        bor_now && !bor_seen |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_BOR])
        else $error("brown-out not recorded");
    wreg_ptr_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        wreg_uninit |=> !system_reset_n_o && reset_cause_flags[`RCC_BIT_ILL])
        else $error("uninitialised pointer use not caught");
endmodule // rcc_reset_cause

// File: verif/rcc_core_model.sv
// rcc_core_model.sv: behavioural core side (decoder, watchdog, trap logic, reset pin)
// assumes: bench calls fire() and pin(); one event at a time, each pulse one ref_clk_i cycle
module rcc_core_model (
    // clock
    input  wire logic   ref_clk_i,
    // event pulses, payload and pin
    output logic [10:0] pulse_o,
    output logic [23:0] data_o,
    output logic        pin_n_o
);
    // pulse_o bits: 0 sw reset, 1 dog timeout, 2 trap, 3 instr, 4 ptr use, 5 security,
    // 6 power save, 7 dog clear, 8 wake, 9 wreg write, 10 clock select write
    initial begin
        pulse_o = 11'h000;
        data_o = 24'h000000;
        pin_n_o = 1'b1;
    end
    task automatic fire(input int k, input logic [23:0] v);
        @(posedge ref_clk_i);
        pulse_o[k] <= 1'b1;
        data_o <= v;
        @(posedge ref_clk_i);
        pulse_o <= 11'h000;
        // payload is stale now, so show its inverse rather than a lucky value
        data_o <= ~v;
    endtask
    // no pull-up on the pin, so it is always driven
    task automatic pin(input logic lvl);
        @(posedge ref_clk_i);
        pin_n_o <= lvl;
    endtask
endmodule // rcc_core_model

// File: verif/rcc_reset_cause_tb.sv
// rcc_reset_cause_tb.sv: self-checking bench for the reset cause block
// assumes: rcc_core_model drives the core side; this bench is the axi4-lite master
module rcc_reset_cause_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { int k; logic [23:0] v; logic [31:0] fl; } rcc_row_t;
    logic        ref_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        brownout_i = 1'b0;
    logic [10:0] pulse;
    logic [23:0] wd;
    logic        pin_n, system_reset_n_o, vector_fetch_o, wake_o;
    logic [15:0] wreg_init_o;
    logic [2:0]  clk_sel_o;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, wk;
    logic [1:0]  bresp, rresp, r, br;
    int          n_fail = 0;
    int          checks = 0;
    rcc_row_t    rows[6] = '{'{0, 24'h0, 32'h40}, '{1, 24'h0, 32'h10}, '{2, 24'hED, 32'h8000},
                           '{3, 24'h3F1234, 32'h4000}, '{4, 24'h3, 32'h4000}, '{5, 24'h0, 32'h4000}};
    always #2.5 ref_clk_i = ~ref_clk_i;
    rcc_core_model u_core (.ref_clk_i(ref_clk_i), .pulse_o(pulse), .data_o(wd), .pin_n_o(pin_n));
    rcc_reset_cause uut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .brownout_i(brownout_i),
        .instr_valid_i(pulse[3]), .instr_word_i(wd), .sw_reset_instr_i(pulse[0]),
        .power_save_instr_i(pulse[6]), .power_save_idle_i(wd[0]), .wdog_clear_instr_i(pulse[7]),
        .wake_i(pulse[8]), .wreg_wr_i(pulse[9]), .wreg_wr_idx_i(wd[3:0]), .wreg_ptr_use_i(pulse[4]),
        .wreg_ptr_idx_i(wd[3:0]), .security_reset_i(pulse[5]), .dog_timer_timeout_i(pulse[1]),
        .trap_active_i(pulse[2]), .trap_active_lvl_i(wd[7:4]), .trap_new_i(pulse[2]),
        .trap_new_lvl_i(wd[3:0]), .clk_sel_new_i(wd[2:0]), .clk_sel_wr_i(pulse[10]),
        .ext_reset_pin_n_i(pin_n), .system_reset_n_o(system_reset_n_o), .vector_fetch_o(vector_fetch_o),
        .wake_o(wake_o), .wreg_init_o(wreg_init_o), .clk_sel_o(clk_sel_o),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bit aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge ref_clk_i);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (awready === 1'b1) aw_ok = 1'b1;
            if (wready === 1'b1) w_ok = 1'b1;
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (!(aw_ok && w_ok));
        while (bvalid !== 1'b1) @(posedge ref_clk_i);
        br = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge ref_clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge ref_clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk_i);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    // reset must stay released; wake pulses are collected on the way
    task automatic quiet(input string nm);
        wk = 1'b0;
        repeat (4) begin
            #1;
            wk = wk | wake_o;
            check(nm, system_reset_n_o, 32'h1);
            @(posedge ref_clk_i);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #50us;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(8'h00, d, r);
        check("cold flags", d, 32'h3);
        u_core.fire(10, 24'h5);
        #1;
        check("clk sel", clk_sel_o, 32'h5);
        foreach (rows[i]) begin
            wr(8'h00, 32'h0);
            u_core.fire(rows[i].k, rows[i].v);
            #1;
            check("reset low", system_reset_n_o, 32'h0);
            @(posedge ref_clk_i);
            #1;
            check("release fetch", {system_reset_n_o, vector_fetch_o}, 32'h3);
            check("wreg init", wreg_init_o, 32'h8000);
            check("clk kept", clk_sel_o, 32'h5);
            rd(8'h00, d, r);
            check("cause", d, rows[i].fl);
        end
        // flags 0x4000 remain; pin reset must add to them
        u_core.pin(1'b0);
        repeat (4) @(posedge ref_clk_i);
        #1;
        check("pin reset", system_reset_n_o, 32'h0);
        u_core.pin(1'b1);
        repeat (8) @(posedge ref_clk_i);
        rd(8'h00, d, r);
        check("pin flags", d, 32'h4080);
        brownout_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        brownout_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        rd(8'h00, d, r);
        check("brownout flags", d, 32'h82);
        wr(8'h00, 32'hC0DF);
        rd(8'h00, d, r);
        check("sw set", d, 32'hC0DF);
        check("wr okay", br, 32'h0);
        wstrb <= 4'h1;
        wr(8'h00, 32'h0);
        wstrb <= 4'hF;
        rd(8'h00, d, r);
        check("low lane", d, 32'hC000);
        wr(8'h00, 32'h10);
        u_core.fire(6, 24'h0);
        rd(8'h00, d, r);
        check("psave clr", d[4], 32'h0);
        u_core.fire(1, 24'h0);
        quiet("sleep dog");
        check("dog wake", wk, 32'h1);
        u_core.fire(8, 24'h0);
        wr(8'h00, 32'h10);
        u_core.fire(7, 24'h0);
        rd(8'h00, d, r);
        check("dog clr", d[4], 32'h0);
        u_core.fire(2, 24'hDE);
        quiet("no conflict");
        u_core.fire(9, 24'h3);
        #1;
        check("wreg written", wreg_init_o[3], 32'h1);
        u_core.fire(4, 24'h3);
        quiet("init ptr");
        rd(8'h10, d, r);
        check("unmapped resp", r, 32'h2);
        check("unmapped data", d, 32'h0);
        wr(8'h10, 32'hFFFF);
        check("unmapped wr", br, 32'h2);
        rd(8'h00, d, r);
        check("flags kept", d, 32'h0);
        tally_and_finish();
    end
endmodule // rcc_reset_cause_tb
